// [rtl/ficc_pkg.sv]
// Package for the four-level interrupt controller: source indices, vectors, structs
package ficc_pkg;

  localparam int NUM_SRC = 20;

  // Source indices in fixed arbitration rank, index 0 wins ties
  localparam int SRC_EXT0   = 0;
  localparam int SRC_TMR0   = 1;
  localparam int SRC_EXT1   = 2;
  localparam int SRC_TMR1   = 3;
  localparam int SRC_SER0   = 4;
  localparam int SRC_TMR2   = 5;
  localparam int SRC_CONV   = 6;
  localparam int SRC_TWI    = 7;
  localparam int SRC_SER1   = 8;
  localparam int SRC_SPI    = 9;
  localparam int SRC_EXT2   = 10;
  localparam int SRC_EXT3   = 11;
  localparam int SRC_EXT4   = 12;
  localparam int SRC_EXT5   = 13;
  localparam int SRC_PWMP   = 14;
  localparam int SRC_PWMB   = 15;
  localparam int SRC_TMR3   = 16;
  localparam int SRC_CAPT   = 17;
  localparam int SRC_NVM    = 18;
  localparam int SRC_WDOG   = 19;

  // Vector addresses indexed by rank
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
    16'h002B, 16'h0033, 16'h003B, 16'h007B, 16'h0083,
    16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0073,
    16'h006B, 16'h008B, 16'h0093, 16'h009B, 16'h0063
  };

  // Machine cycle length minus one in core clocks, and length of the hardware call in machine cycles
  localparam logic [1:0] MC_CLOCKS_M1   = 2'h3;
  localparam logic [2:0] CALL_MCYCLES   = 3'h4;

  // Reset values
  localparam logic [NUM_SRC-1:0] FLAG_RST  = 20'h0_0000;
  localparam logic [3:0]         INSV_RST  = 4'h0;
  localparam logic [15:0]        VEC_RST   = 16'h0000;

  // Edge select field: two bits per input 3..5, bit0 rising, bit1 falling
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  typedef struct packed {
    logic                global_irq_enable;
    logic [NUM_SRC-1:0]  enable;
    logic [NUM_SRC-1:0]  prio_hi;
    logic [NUM_SRC-1:0]  prio_lo;
    logic                trigger_select_0;
    logic                trigger_select_1;
    logic [3:0]          hw_clear_enable;
    logic [5:0]          edge_select_field;
  } ficc_cfg_type;

  typedef struct packed {
    logic last_cycle;
    logic writes_irq_regs;
    logic is_return;
  } ficc_core_type;

endpackage

// [rtl/ficc_top.sv]
// Four-level interrupt controller with flags, ranking and hardware call sequencing
`timescale 1ns/1ns
module ficc_top
  import ficc_pkg::*;
(
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_i,
  input  wire ficc_pkg::ficc_cfg_type    cfg_i,
  input  wire ficc_pkg::ficc_core_type   core_i,
  input  wire logic                      return_from_interrupt_i,
  input  wire logic [5:0]                ext_req_pin_i,
  input  wire logic [ficc_pkg::NUM_SRC-1:0] hw_event_i,
  input  wire logic [ficc_pkg::NUM_SRC-1:0] sw_flag_wr_i,
  input  wire logic [ficc_pkg::NUM_SRC-1:0] sw_flag_val_i,
  input  wire logic                      timer2_evt_ovf_i,
  input  wire logic                      timer2_evt_cap_i,
  output logic [ficc_pkg::NUM_SRC-1:0]   flags_o,
  output logic                           timer2_overflow_flag_o,
  output logic                           timer2_event_flag_o,
  output logic                           mcycle_strobe_o,
  output logic                           call_busy_o,
  output logic                           push_pc_o,
  output logic                           load_vector_o,
  output logic [15:0]                    vector_o,
  output logic [3:0]                     in_service_o
);
  import ficc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    CALL_IDLE = 3'b001,
    CALL_RUN  = 3'b010,
    CALL_LOAD = 3'b100
  } ficc_call_type;

  function automatic logic [1:0] src_level(input ficc_cfg_type c, input int i);
    src_level = {c.prio_hi[i], c.prio_lo[i]};
  endfunction

  function automatic logic [1:0] top_level(input logic [3:0] m);
    top_level = m[3] ? 2'd3 : m[2] ? 2'd2 : m[1] ? 2'd1 : 2'd0;
  endfunction

  logic [1:0]         mc_cnt_q;
  logic               mc_end;
  logic [2:0]         pin_s1_q [6];
  logic [5:0]         pin_sync;
  logic [5:0]         pin_smp_q;
  logic [5:0]         pin_prev_q;
  logic [NUM_SRC-1:0] flag_q;
  logic               t2_ovf_q;
  logic               t2_evt_q;
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] hw_clr;
  logic [NUM_SRC-1:0] ext_set;
  logic               win_valid;
  logic [4:0]         win_idx;
  logic [1:0]         win_lvl;
  logic               take_call;
  ficc_call_type      call_q;
  logic [2:0]         call_cnt_q;
  logic [4:0]         call_idx_q;
  logic [3:0]         insv_q;
  logic [15:0]        vec_q;
  logic               push_q;
  logic               load_q;

  //////////////////////////////////////////////////////////////////////////////
  // Machine cycle: four core clocks
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mc_cnt_q <= 2'h0;
    end else begin
      mc_cnt_q <= mc_cnt_q + 2'h1;
    end
  end
  assign mc_end = (mc_cnt_q == MC_CLOCKS_M1);

  // Three-stage pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 6; i++) pin_s1_q[i] <= 3'b111;
    end else begin
      for (int i = 0; i < 6; i++) pin_s1_q[i] <= {pin_s1_q[i][1:0], ext_req_pin_i[i]};
    end
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_sync[i] = (pin_s1_q[i][2] == pin_s1_q[i][1]) ? pin_s1_q[i][2] : pin_smp_q[i];
    end
  end

  // per-cycle sampling
  // Pins sampled once per machine cycle so pulses under one cycle may be missed
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_smp_q  <= 6'h3F;
      pin_prev_q <= 6'h3F;
    end else if (mc_end) begin
      pin_smp_q  <= pin_sync;
      pin_prev_q <= pin_smp_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection per external input
  always_comb begin
    ext_set = '0;
    if (mc_end) begin
      ext_set[SRC_EXT0] = pin_prev_q[0] & ~pin_smp_q[0];
      ext_set[SRC_EXT1] = pin_prev_q[1] & ~pin_smp_q[1];
      ext_set[SRC_EXT2] = pin_prev_q[2] & ~pin_smp_q[2];
      for (int k = 0; k < 3; k++) begin
        ext_set[SRC_EXT3+k] =
          (cfg_i.edge_select_field[2*k+EDGE_RISE_BIT] & ~pin_prev_q[3+k] & pin_smp_q[3+k]) |
          (cfg_i.edge_select_field[2*k+EDGE_FALL_BIT] & pin_prev_q[3+k] & ~pin_smp_q[3+k]);
      end
    end
  end

  // Hardware clear on vector entry
  always_comb begin
    hw_clr = '0;
    hw_clr[SRC_EXT0] = ~cfg_i.trigger_select_0 ? 1'b0 : 1'b1;
    hw_clr[SRC_EXT1] = ~cfg_i.trigger_select_1 ? 1'b0 : 1'b1;
    hw_clr[SRC_TMR0] = 1'b1;
    hw_clr[SRC_TMR1] = 1'b1;
    for (int k = 0; k < 4; k++) hw_clr[SRC_EXT2+k] = cfg_i.hw_clear_enable[k];
    // software-only flags keep zero here, watchdog too
  end

  //////////////////////////////////////////////////////////////////////////////
  // twenty flags, four levels
  // Flags: a hardware set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_q <= FLAG_RST;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (i == SRC_TMR2) begin
          // request is OR of both flags
          flag_q[i] <= t2_ovf_q | t2_evt_q;
        end else if ((i == SRC_EXT0 && !cfg_i.trigger_select_0) ||
                     (i == SRC_EXT1 && !cfg_i.trigger_select_1)) begin
          flag_q[i] <= ~pin_smp_q[i == SRC_EXT0 ? 0 : 1];
        end else if (hw_event_i[i] || ext_set[i]) begin
          flag_q[i] <= 1'b1;
        end else if (sw_flag_wr_i[i]) begin
          flag_q[i] <= sw_flag_val_i[i];
        end else if (load_q && call_idx_q == 5'(i) && hw_clr[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // timer two flags, software clear only
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      t2_ovf_q <= 1'b0;
      t2_evt_q <= 1'b0;
    end else begin
      if (timer2_evt_ovf_i) t2_ovf_q <= 1'b1;
      else if (sw_flag_wr_i[SRC_TMR2]) t2_ovf_q <= sw_flag_val_i[SRC_TMR2];
      if (timer2_evt_cap_i) t2_evt_q <= 1'b1;
      else if (sw_flag_wr_i[SRC_TMR2]) t2_evt_q <= sw_flag_val_i[SRC_TMR2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // enable gating
  assign req = cfg_i.global_irq_enable ? (flag_q & cfg_i.enable) : '0;

  always_comb begin
    win_valid = 1'b0;
    win_idx   = 5'h0;
    win_lvl   = 2'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && (!win_valid || src_level(cfg_i, i) >= win_lvl)) begin
        win_valid = 1'b1;
        win_idx   = 5'(i);
        win_lvl   = src_level(cfg_i, i);
      end
    end
  end

  // poll every machine cycle, no latching
  assign take_call = mc_end && win_valid && (call_q == CALL_IDLE) &&
                     (insv_q == INSV_RST || win_lvl > top_level(insv_q)) &&
                     core_i.last_cycle && !core_i.writes_irq_regs && !core_i.is_return;

  //////////////////////////////////////////////////////////////////////////////
  // four machine cycle call: push then load vector
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      call_q     <= CALL_IDLE;
      call_cnt_q <= 3'h0;
      call_idx_q <= 5'h0;
      push_q     <= 1'b0;
      load_q     <= 1'b0;
      vec_q      <= VEC_RST;
    end else begin
      push_q <= 1'b0;
      load_q <= 1'b0;
      case (call_q)
        CALL_IDLE: begin
          if (take_call) begin
            call_q     <= CALL_RUN;
            call_cnt_q <= 3'h1;
            call_idx_q <= win_idx;
            push_q     <= 1'b1;
          end
        end
        CALL_RUN: begin
          if (mc_end) begin
            call_cnt_q <= call_cnt_q + 3'h1;
            if (call_cnt_q == CALL_MCYCLES - 3'h1) begin
              call_q <= CALL_LOAD;
            end
          end
        end
        CALL_LOAD: begin
          if (mc_end) begin
            vec_q  <= VEC_TABLE[call_idx_q];
            load_q <= 1'b1;
            call_q <= CALL_IDLE;
          end
        end
        default: call_q <= CALL_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      insv_q <= INSV_RST;
    end else begin
      // A return and a new call in one cycle both take effect
      if (return_from_interrupt_i && insv_q != INSV_RST) begin
        insv_q[top_level(insv_q)] <= 1'b0;
      end
      if (take_call) begin
        insv_q[win_lvl] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      flags_o                <= FLAG_RST;
      timer2_overflow_flag_o <= 1'b0;
      timer2_event_flag_o    <= 1'b0;
      mcycle_strobe_o        <= 1'b0;
      call_busy_o            <= 1'b0;
      in_service_o           <= INSV_RST;
    end else begin
      flags_o                <= flag_q;
      timer2_overflow_flag_o <= t2_ovf_q;
      timer2_event_flag_o    <= t2_evt_q;
      mcycle_strobe_o        <= mc_end;
      call_busy_o            <= (call_q != CALL_IDLE) || take_call;
      in_service_o           <= insv_q;
    end
  end

  assign push_pc_o     = push_q;
  assign load_vector_o = load_q;
  assign vector_o      = vec_q;

endmodule

// [bench/ficc_properties.sv]
// Port-level checker for the four-level interrupt controller
`timescale 1ns/1ns
module ficc_properties
  import ficc_pkg::*;
(
  input  wire logic                         ref_clk_i,
  input  wire logic                         reset_i,
  input  wire ficc_pkg::ficc_cfg_type       cfg_i,
  input  wire ficc_pkg::ficc_core_type      core_i,
  input  wire logic                         return_from_interrupt_i,
  input  wire logic [ficc_pkg::NUM_SRC-1:0] sw_flag_wr_i,
  input  wire logic [ficc_pkg::NUM_SRC-1:0] flags_o,
  input  wire logic                         push_pc_o,
  input  wire logic                         mcycle_strobe_o,
  input  wire logic                         call_busy_o,
  input  wire logic                         load_vector_o,
  input  wire logic [15:0]                  vector_o,
  input  wire logic [3:0]                   in_service_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_mc_period; mcycle_strobe_o |=> !mcycle_strobe_o [*3] ##1 mcycle_strobe_o; endproperty
  a_mc_period: assert property (p_mc_period) else $error("machine cycle not four clocks");
  property p_push_busy; push_pc_o |-> call_busy_o ##1 call_busy_o; endproperty
  a_push_busy: assert property (p_push_busy) else $error("push outside a busy call");
  property p_push_once; push_pc_o |=> !push_pc_o [*8]; endproperty
  a_push_once: assert property (p_push_once) else $error("push repeated");
  // Load lands 11 to 16 clocks after the push: four machine cycles
  property p_call_len; push_pc_o |=> !load_vector_o [*8] ##[3:8] load_vector_o; endproperty
  a_call_len: assert property (p_call_len) else $error("call length wrong");
  property p_vec_hold; $changed(vector_o) |-> load_vector_o; endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved without load");
  property p_global; push_pc_o |-> $past(cfg_i.global_irq_enable); endproperty
  a_global: assert property (p_global) else $error("call while globally disabled");
  property p_cond;
    push_pc_o |-> !$past(core_i.writes_irq_regs) && !$past(core_i.is_return);
  endproperty
  a_cond: assert property (p_cond) else $error("call on refused instruction");
  property p_top_level; push_pc_o |-> !$past(in_service_o[3]); endproperty
  a_top_level: assert property (p_top_level) else $error("level three preempted");
  property p_ret_only;
    (in_service_o < $past(in_service_o)) |->
      $past(return_from_interrupt_i) || $past(return_from_interrupt_i, 2);
  endproperty
  a_ret_only: assert property (p_ret_only) else $error("marker dropped without return");
  property p_wdog_sw;
    $fell(flags_o[SRC_WDOG]) |-> $past(sw_flag_wr_i[SRC_WDOG], 2) ||
      $past(sw_flag_wr_i[SRC_WDOG], 3) || $past(sw_flag_wr_i[SRC_WDOG]);
  endproperty
  a_wdog_sw: assert property (p_wdog_sw) else $error("watchdog flag cleared by hardware");
endmodule
bind ficc_top ficc_properties u_props (.ref_clk_i, .reset_i, .cfg_i, .core_i,
  .return_from_interrupt_i, .sw_flag_wr_i, .flags_o, .push_pc_o, .mcycle_strobe_o, .call_busy_o,
  .load_vector_o, .vector_o, .in_service_o);

// [bench/ficc_core_model.sv]
// Behavioural core sequencer giving instruction-boundary status and returns
`timescale 1ns/1ns
module ficc_core_model
  import ficc_pkg::*;
(
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  input  wire logic               mcycle_strobe_i,
  input  wire logic               slow_i,
  input  wire logic               wr_regs_i,
  input  wire logic               ret_req_i,
  output ficc_pkg::ficc_core_type core_o,
  output logic                    rti_o
);
  logic odd_q;
  logic ret_q;
  // Slow mode stands for two-cycle instructions, so half the polls are refused
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      odd_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      odd_q <= odd_q ^ mcycle_strobe_i;
      ret_q <= ret_req_i;
    end
  end
  assign core_o = '{last_cycle: !slow_i || odd_q, writes_irq_regs: wr_regs_i, is_return: ret_req_i};
  // one return pulse per returning instruction
  assign rti_o = ret_req_i && !ret_q;
endmodule

// [bench/ficc_top_tb.sv]
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/1ns
module ficc_top_tb;
  import ficc_pkg::*;
  logic                 ref_clk_i = 1'b0;
  logic                 reset_i = 1'b1;
  ficc_cfg_type         cfg = '0;
  ficc_core_type        core;
  logic                 rti;
  logic                 wr_cmd = 1'b0;
  logic                 slow = 1'b0;
  logic                 ret_req = 1'b0;
  logic [5:0]           pins = 6'h07;
  logic [NUM_SRC-1:0]   hw_ev = '0;
  logic [NUM_SRC-1:0]   swr = '0;
  logic [NUM_SRC-1:0]   swv = '0;
  logic                 t2o = 1'b0;
  logic                 t2c = 1'b0;
  logic [NUM_SRC-1:0]   flags;
  logic                 t2of, t2ef, mstb, busy, push, load;
  logic [15:0]          vec;
  logic [3:0]           insv;
  int                   fails = 0;
  int                   samples_checked = 0;
  logic [15:0]          exp_vec [NUM_SRC] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
    16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h007B, 16'h0083, 16'h0043, 16'h004B,
    16'h0053, 16'h005B, 16'h0073, 16'h006B, 16'h008B, 16'h0093, 16'h009B, 16'h0063};
  always #50 ref_clk_i = ~ref_clk_i;
  ficc_top uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cfg_i(cfg), .core_i(core),
    .return_from_interrupt_i(rti), .ext_req_pin_i(pins), .hw_event_i(hw_ev),
    .sw_flag_wr_i(swr), .sw_flag_val_i(swv), .timer2_evt_ovf_i(t2o), .timer2_evt_cap_i(t2c),
    .flags_o(flags), .timer2_overflow_flag_o(t2of), .timer2_event_flag_o(t2ef),
    .mcycle_strobe_o(mstb), .call_busy_o(busy), .push_pc_o(push), .load_vector_o(load),
    .vector_o(vec), .in_service_o(insv));
  ficc_core_model core_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .mcycle_strobe_i(mstb), .slow_i(slow), .wr_regs_i(wr_cmd), .ret_req_i(ret_req),
    .core_o(core), .rti_o(rti));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic swr_set(input logic [NUM_SRC-1:0] m, input logic v);
    swr = m;
    swv = v ? m : '0;
    cyc(1);
    swr = '0;
    cyc(1);
  endtask
  // Bounded wait for a vector load; ends on a falling edge
  task automatic wait_call(input int lim, output logic [15:0] v, output logic got);
    got = 1'b0;
    v = 16'h0000;
    repeat (lim) begin
      @(posedge ref_clk_i);
      #1;
      if (load === 1'b1 && !got) begin
        got = 1'b1;
        v = vec;
      end
    end
    @(negedge ref_clk_i);
  endtask
  // Flags are cleared while the return holds off a fresh call
  task automatic finish_isr(input logic [NUM_SRC-1:0] m);
    ret_req = 1'b1;
    swr_set(m, 1'b0);
    cyc(4);
    ret_req = 1'b0;
    cyc(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_events;
    hw_ev[SRC_TMR0] = 1'b1;
    hw_ev[SRC_CONV] = 1'b1;
    hw_ev[SRC_TWI] = 1'b1;
    hw_ev[SRC_WDOG] = 1'b1;
    t2o = 1'b1;
    cyc(1);
    hw_ev = '0;
    t2o = 1'b0;
    t2c = 1'b1;
    cyc(1);
    t2c = 1'b0;
    cyc(3);
    chk("event_flags", 16'h007F, {9'h000, flags[SRC_WDOG], flags[SRC_TWI], flags[SRC_CONV],
      flags[SRC_TMR0], flags[SRC_TMR2], t2of, t2ef});
    swr_set(20'h8_00E2, 1'b0);
  endtask
  task automatic t_pins;
    cfg.trigger_select_0 = 1'b1;
    cfg.edge_select_field = 6'h31;
    pins = 6'h28; // levels held well past one machine cycle
    cyc(16);
    chk("pin_flags", 16'h002F, {10'h000, flags[13:10], flags[2], flags[0]});
    pins[1] = 1'b1;
    cyc(16);
    chk("level_flag", 16'h0000, {15'h0000, flags[2]});
    swr_set(20'h0_3C01, 1'b0);
  endtask
  task automatic t_vectors;
    logic [15:0] v;
    logic got;
    logic [NUM_SRC-1:0] hwclr;
    hwclr = 20'h0_3C0F;
    cfg.global_irq_enable = 1'b1;
    cfg.trigger_select_1 = 1'b1;
    cfg.hw_clear_enable = 4'hF;
    for (int i = 0; i < NUM_SRC; i++) begin
      slow = i[0];
      cfg.enable = 20'h0_0001 << i;
      swr_set(cfg.enable, 1'b1);
      wait_call(60, v, got);
      chk("vector", exp_vec[i], v);
      cyc(3);
      chk("flag_after_call", {15'h0000, !hwclr[i]}, {15'h0000, flags[i]});
      chk("in_service", 16'h0001, {12'h000, insv});
      finish_isr(cfg.enable);
      chk("in_service", 16'h0000, {12'h000, insv});
    end
    slow = 1'b0;
  endtask
  task automatic t_race(input int a, input int b, input logic [1:0] lb, input int w);
    logic [15:0] v;
    logic got;
    cfg.enable = '0;
    cfg.enable[a] = 1'b1;
    cfg.enable[b] = 1'b1;
    cfg.prio_hi = '0;
    cfg.prio_lo = '0;
    cfg.prio_hi[b] = lb[1];
    cfg.prio_lo[b] = lb[0];
    swr_set(cfg.enable, 1'b1);
    wait_call(60, v, got);
    chk("race_vector", exp_vec[w], v);
    chk("race_level", 16'h0001 << ((w == b) ? lb : 2'h0), {12'h000, insv});
    finish_isr(cfg.enable);
  endtask
  task automatic t_preempt;
    logic [15:0] v;
    logic got;
    cfg.enable = 20'h0_8010;
    cfg.prio_hi = 20'h0_8010;
    cfg.prio_lo = 20'h0_0010;
    swr_set(20'h0_8000, 1'b1);
    wait_call(60, v, got);
    chk("level2_vector", 16'h006B, v);
    swr_set(20'h0_0010, 1'b1);
    wait_call(60, v, got);
    chk("preempt_levels", 16'h000C, {12'h000, insv});
    swr_set(20'h0_8000, 1'b1);
    wait_call(40, v, got);
    chk("level3_kept", 16'h0000, {15'h0000, got});
    finish_isr(20'h0_0010);
    finish_isr(20'h0_8000);
    chk("in_service", 16'h0000, {12'h000, insv});
  endtask
  task automatic t_refuse;
    logic [15:0] v;
    logic got;
    cfg.enable = 20'h0_0040;
    cfg.global_irq_enable = 1'b0;
    swr_set(20'h0_0040, 1'b1);
    wait_call(40, v, got);
    chk("global_off", 16'h0000, {15'h0000, got});
    wr_cmd = 1'b1;
    cyc(1);
    cfg.global_irq_enable = 1'b1;
    wait_call(40, v, got);
    chk("reg_write", 16'h0000, {15'h0000, got});
    swr_set(20'h0_0040, 1'b0);
    wr_cmd = 1'b0;
    wait_call(40, v, got);
    chk("vanished", 16'h0000, {15'h0000, got});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    reset_i = 1'b0;
    cyc(2);
    t_events;
    t_pins;
    t_vectors;
    t_race(SRC_TMR0, SRC_WDOG, 2'h0, SRC_TMR0);
    t_race(SRC_TMR0, SRC_WDOG, 2'h2, SRC_WDOG);
    t_race(SRC_CONV, SRC_SER1, 2'h1, SRC_SER1);
    t_race(SRC_EXT2, SRC_EXT3, 2'h0, SRC_EXT2);
    t_preempt;
    t_refuse;
    complete_run;
  end
  // Run needs about 2100 clocks; the limit leaves ample margin
  initial begin
    #2_000_000;
    fails++;
    complete_run;
  end
endmodule
